// File: adc_core_warmup_ready_irq_test.sv
// Self-checking bench for the core warm-up and ready-interrupt block
`include "adcw_map.svh"

module adc_core_warmup_ready_irq_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        tick;
   logic        shr;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [3:0]  pstrb;
   logic [3:0]  core_ready;
   logic [3:0]  core_power_on;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [31:0] rd;
   logic        er;
   logic [3:0]  cd [4];
   int          error_cnt;
   int          check_count;
   int          cyc;
   int          n;

   adcw_ctrl i_adcw_ctrl (
      .clk               (clk),
      .nrst              (nrst),
      .paddr             (paddr),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .pwdata            (pwdata),
      .pstrb             (pstrb),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .core_src_tick     (tick),
      .shared_core_ready (shr),
      .core_ready        (core_ready),
      .core_power_on     (core_power_on),
      .irq               (irq)
   );

   ////////////////////////////////////////////////////////////////////////////

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   task automatic test_done;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // A stuck bus or counter must still end in the closing report
   always @(posedge clk) begin
      cyc++;
      if (cyc == 25000) begin
         error_cnt++;
         test_done;
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   // One APB transfer; releases, then lets an edge pass before returning
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      // Only the bench timeout ends a wait for pready
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   task automatic wait_ready(input int i);
      n = 0;
      while (core_ready[i] !== 1'h1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////

   initial begin
      nrst    <= 1'h0;
      psel    <= 1'h0;
      penable <= 1'h0;
      pwrite  <= 1'h0;
      paddr   <= 8'h00;
      pwdata  <= 32'h0;
      pstrb   <= 4'hf;
      tick    <= 1'h1;
      shr     <= 1'h0;
      cd      = '{4'h1, 4'h2, 4'h7, 4'he};
      repeat (4) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      apb(1'h0, `ADCW_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'h1, `ADCW_OFF_CTRL, 32'hffff);
      apb(1'h0, `ADCW_OFF_CTRL, 32'h0);
      chk(rd, 32'h0f8f);
      chk(32'(irq), 32'h0);
      // Tick every cycle so the delay in cycles equals the tick count
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, `ADCW_OFF_CTRL, 32'({cd[i], 8'h00}) | (32'h1 << i));
         apb(1'h1, `ADCW_OFF_POWER, 32'h1 << i);
         wait_ready(i);
         chk(32'(n >= (1 << cd[i]) && n <= (1 << cd[i]) + 3), 32'h1);
         repeat (2) @(posedge clk);
         chk(32'(irq), 32'h1);
         apb(1'h0, `ADCW_OFF_STATUS, 32'h0);
         chk(rd, 32'h1 << i);
         apb(1'h1, `ADCW_OFF_CLEAR, 32'h1 << i);
         chk(32'(irq), 32'h0);
      end
      apb(1'h1, `ADCW_OFF_POWER, 32'h0);
      @(posedge clk);
      chk(32'(core_ready), 32'h0);
      chk(32'(core_power_on), 32'h0);
      apb(1'h1, `ADCW_OFF_CTRL, 32'h0100);
      apb(1'h1, `ADCW_OFF_POWER, 32'h2);
      apb(1'h0, `ADCW_OFF_POWER, 32'h0);
      chk(rd, 32'h2);
      chk(32'(core_power_on), 32'h2);
      wait_ready(1);
      repeat (2) @(posedge clk);
      apb(1'h0, `ADCW_OFF_STATUS, 32'h0);
      chk(rd, 32'h2);
      chk(32'(irq), 32'h0);
      shr <= 1'h1;
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0);
      apb(1'h0, `ADCW_OFF_READY, 32'h0);
      chk(rd, 32'h82);
      apb(1'h1, `ADCW_OFF_CTRL, 32'h0080);
      chk(32'(irq), 32'h1);
      apb(1'h1, `ADCW_OFF_CLEAR, 32'h82);
      chk(32'(irq), 32'h0);
      // Shared ready edge in the very cycle of its clear: the set wins
      shr <= 1'h0;
      @(posedge clk);
      fork
         apb(1'h1, `ADCW_OFF_CLEAR, 32'h80);
         begin
            @(posedge clk);
            shr <= 1'h1;
         end
      join
      chk(32'(irq), 32'h1);
      apb(1'h1, `ADCW_OFF_CLEAR, 32'h80);
      chk(32'(irq), 32'h0);
      // Refused accesses must leave status untouched
      apb(1'h0, 8'h20, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      apb(1'h1, `ADCW_OFF_STATUS, 32'hff);
      chk(32'(er), 32'h1);
      apb(1'h0, `ADCW_OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      test_done;
   end

endmodule

// File: adcw_ctrl.sv
// APB register block for converter core warm-up and ready interrupts
//
// Function
// - Bits 11:8 set delay of two-power-n periods
// - Bit 7 set: shared core ready interrupts
// - Bit 7 clear: shared ready interrupt masked, the event still sets status
// - Bit 3 enables core 3 ready interrupt
// - Bit 2 enables core 2 ready interrupt
`include "adcw_map.svh"

module adcw_ctrl #(
   parameter int ADDR_W = 8,
   parameter int NCORE  = 4,
   parameter int CNT_W  = 16
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              core_src_tick,
   input  wire logic              shared_core_ready,
   output logic [NCORE-1:0]       core_ready,
   output logic [NCORE-1:0]       core_power_on,
   output logic                   irq
);

   if (NCORE != `ADCW_NCORE || ADDR_W < 5 ||
       CNT_W < `ADCW_CNT_MIN) begin : g_chk
      $error("adcw_ctrl: unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   adcw_pkg::adcw_ctrl_t ctrl_q, ctrl_d;
   logic [NCORE-1:0]     pwr_q, pwr_d;
   adcw_pkg::adcw_evt_t  stat_q, stat_d;
   logic [NCORE-1:0]     rdy_q;
   logic                 shr_q;
   logic [31:0]          rdata_q, rdata_d;
   logic                 err_q, err_d;
   logic                 setup;
   logic                 wr_acc;
   adcw_pkg::adcw_evt_t  evt;
   adcw_pkg::adcw_evt_t  clr;
   adcw_pkg::adcw_evt_t  en;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
      return a == ADDR_W'(off);
   endfunction

   // Byte-lane merge, bits outside the mask keep their old value
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] wd,
                                         input logic [1:0]  st,
                                         input logic [15:0] msk);
      logic [15:0] lane;
      lane = {{8{st[1]}}, {8{st[0]}}} & msk;
      return (old & ~lane) | (wd & lane);
   endfunction

   // Registered read data costs one setup cycle but keeps prdata glitch-free
   assign setup  = psel && !penable;
   assign pready = psel && penable;
   assign wr_acc = psel && penable && pwrite && !err_q;
   assign prdata = rdata_q;
   assign pslverr = pready && err_q;

   // Refused words answer with pslverr and change no register
   always_comb begin
      rdata_d = rdata_q;
      err_d   = err_q;
      if (setup) begin
         rdata_d = '0;
         err_d   = 1'b0;
         if (hit(paddr, `ADCW_OFF_CTRL)) begin
            rdata_d[15:0] = ctrl_q & `ADCW_CTRL_WMASK;
         end else if (hit(paddr, `ADCW_OFF_POWER)) begin
            rdata_d[NCORE-1:0] = pwr_q;
         end else if (hit(paddr, `ADCW_OFF_STATUS)) begin
            rdata_d[7:0] = stat_q;
            err_d        = pwrite;
         end else if (hit(paddr, `ADCW_OFF_CLEAR)) begin
            err_d = !pwrite;
         end else if (hit(paddr, `ADCW_OFF_READY)) begin
            rdata_d[NCORE-1:0]    = core_ready;
            rdata_d[`ADCW_SHR_BIT] = shared_core_ready;
            err_d                 = pwrite;
         end else begin
            err_d = 1'b1;
         end
         if (pwrite) begin
            rdata_d = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
         err_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         err_q   <= err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control and power registers
   always_comb begin
      ctrl_d = ctrl_q;
      pwr_d  = pwr_q;
      if (wr_acc && hit(paddr, `ADCW_OFF_CTRL)) begin
         ctrl_d = merge(ctrl_q, pwdata[15:0], pstrb[1:0],
                        `ADCW_CTRL_WMASK);
      end
      if (wr_acc && hit(paddr, `ADCW_OFF_POWER) && pstrb[0]) begin
         pwr_d = pwdata[NCORE-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= `ADCW_CTRL_RST;
         pwr_q  <= `ADCW_POWER_RST;
      end else begin
         ctrl_q <= ctrl_d;
         pwr_q  <= pwr_d;
      end
   end

   assign core_power_on = pwr_q;

   ////////////////////////////////////////////////////////////////////////
   // Dedicated cores; all share one delay code
   for (genvar i = 0; i < NCORE; i++) begin : g_core
      adcw_warmup #(
         .CNT_W         (CNT_W)
      ) i_adcw_warmup (
         .clk           (clk),
         .nrst          (nrst),
         .power_on      (pwr_q[i]),
         .core_src_tick (core_src_tick),
         .code          (ctrl_q[`ADCW_CODE_MSB:`ADCW_CODE_LSB]),
         .ready         (core_ready[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Ready events, sticky status and the common request
   // Events are edges of the ready levels: a core that stays ready
   // raises one event, and only a power cycle brings another
   always_comb begin
      evt = '0;
      evt[NCORE-1:0]     = core_ready & ~rdy_q;
      evt[`ADCW_SHR_BIT] = shared_core_ready && !shr_q;
      clr = '0;
      if (wr_acc && hit(paddr, `ADCW_OFF_CLEAR) && pstrb[0]) begin
         clr = pwdata[7:0];
      end
      // A ready edge in the clearing cycle survives the clear
      stat_d = ((stat_q & ~clr) | evt) & `ADCW_EVT_MASK;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stat_q <= `ADCW_STAT_RST;
         rdy_q  <= '0;
         shr_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         rdy_q  <= core_ready;
         shr_q  <= shared_core_ready;
      end
   end

   assign en  = ctrl_q[7:0] & `ADCW_EVT_MASK;
   assign irq = |(stat_q & en);

   ////////////////////////////////////////////////////////////////////////
   // Checks sleep while nrst is low; all of them run on clk
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   delay_code_a: assert property (
      wr_acc && hit(paddr, `ADCW_OFF_CTRL) && pstrb[1] |=>
      ctrl_q[`ADCW_CODE_MSB:`ADCW_CODE_LSB] ==
      $past(pwdata[`ADCW_CODE_MSB:`ADCW_CODE_LSB]))
      else $error("delay code not taken from the write");

   // A control write in the ready cycle may drop the enable, so the
   // request is only demanded while the enable still stands
   shared_irq_a: assert property (
      ctrl_q[7] && $rose(shared_core_ready) |=>
      stat_q[7] && (irq || !ctrl_q[7]))
      else $error("shared core ready did not raise the request");

   shared_mask_a: assert property (
      !ctrl_q[7] && (stat_q[3:0] & ctrl_q[3:0]) == 4'h0 |-> !irq)
      else $error("masked shared ready event raised the request");

   core3_irq_a: assert property (
      ctrl_q[3] && $rose(core_ready[3]) |=>
      stat_q[3] && (irq || !ctrl_q[3]))
      else $error("core 3 ready did not raise the request");

   core2_irq_a: assert property (
      ctrl_q[2] && $rose(core_ready[2]) |=>
      stat_q[2] && (irq || !ctrl_q[2]))
      else $error("core 2 ready did not raise the request");

   core10_irq_a: assert property (
      (ctrl_q[1] && $rose(core_ready[1])) ||
      (ctrl_q[0] && $rose(core_ready[0])) |=>
      irq || ctrl_q[1:0] != $past(ctrl_q[1:0]))
      else $error("core 1 or 0 ready did not raise the request");

   unused_zero_a: assert property (
      pready && !pwrite && hit($past(paddr), `ADCW_OFF_CTRL) |->
      prdata[15:12] == 4'h0 && prdata[6:4] == 3'h0)
      else $error("unimplemented control bits read nonzero");

   sticky_hold_a: assert property (
      stat_q[3] && clr[3] == 1'b0 |=> stat_q[3])
      else $error("ready status dropped without a clear");

   set_wins_a: assert property (
      evt[0] && clr[0] |=> stat_q[0])
      else $error("ready event lost in the clearing cycle");

   irq_cause_a: assert property (
      irq |-> (stat_q[7] && ctrl_q[7]) ||
      (stat_q[3:0] & ctrl_q[3:0]) != 4'h0)
      else $error("request high with no enabled status");

   ////////////////////////////////////////////////////////////////////////
   // Status set and clear, request fall and core 0 power-off
   shr_set_wins_a: assert property (
      evt[`ADCW_SHR_BIT] && clr[`ADCW_SHR_BIT] |=> stat_q[`ADCW_SHR_BIT])
      else $error("shared ready event lost in the clearing cycle");

   shr_clear_a: assert property (
      clr[`ADCW_SHR_BIT] && !evt[`ADCW_SHR_BIT] |=> !stat_q[`ADCW_SHR_BIT])
      else $error("shared ready status not cleared");

   core_clear_a: assert property (
      clr[1] && !evt[1] |=> !stat_q[1])
      else $error("core 1 ready status not cleared");

   core_set_a: assert property (
      evt[2] |=> stat_q[2])
      else $error("core 2 ready event not recorded");

   irq_fall_a: assert property (
      $fell(irq) |-> $past(wr_acc))
      else $error("request dropped without a register write");

   power_off_a: assert property (
      !core_power_on[0] |=> !core_ready[0])
      else $error("core 0 still ready after its power went off");

   ////////////////////////////////////////////////////////////////////////
   // Bus answers
   read_ctrl_a: assert property (
      pready && !pwrite && hit(paddr, `ADCW_OFF_CTRL) |->
      prdata[15:0] == ctrl_q)
      else $error("control read does not match the register");

   power_write_a: assert property (
      wr_acc && hit(paddr, `ADCW_OFF_POWER) && pstrb[0] |=>
      core_power_on == $past(pwdata[NCORE-1:0]))
      else $error("power request not taken from the write");

   refused_write_a: assert property (
      pslverr && pwrite |=>
      ctrl_q == $past(ctrl_q) && core_power_on == $past(core_power_on))
      else $error("refused write changed a register");

   status_refused_a: assert property (
      pready && pwrite && hit(paddr, `ADCW_OFF_STATUS) |-> pslverr)
      else $error("write to the status word not refused");

   write_zero_a: assert property (
      pready && pwrite |-> prdata == 32'h0)
      else $error("read data not zero during a write");

   refused_read_a: assert property (
      pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");

   core_up_c:  cover property ($rose(core_ready[0]));
   irq_up_c:   cover property ($rose(irq));
   shared_c:   cover property (ctrl_q[7] && evt[7]);
   clear_c:    cover property (irq ##1 clr != 8'h00 ##1 !irq);
   shr_race_c: cover property (evt[`ADCW_SHR_BIT] && clr[`ADCW_SHR_BIT]);

endmodule

// File: adcw_map.svh
// Register offsets, field positions, reset values and masks of the warm-up block
`ifndef ADCW_MAP_SVH
`define ADCW_MAP_SVH

`define ADCW_OFF_CTRL      8'h00
`define ADCW_OFF_POWER     8'h04
`define ADCW_OFF_STATUS    8'h08
`define ADCW_OFF_CLEAR     8'h0c
`define ADCW_OFF_READY     8'h10

`define ADCW_CODE_MSB      11
`define ADCW_CODE_LSB      8
`define ADCW_SHR_BIT       7
`define ADCW_CORE_MSB      3

`define ADCW_CTRL_RST      16'h0000
`define ADCW_POWER_RST     4'h0
`define ADCW_STAT_RST      8'h00
`define ADCW_CTRL_WMASK    16'h0f8f
`define ADCW_EVT_MASK      8'h8f

`define ADCW_NCORE         4
`define ADCW_CNT_MIN       16

`endif

// File: adcw_pkg.sv
// Types shared by the warm-up and ready-interrupt block
package adcw_pkg;

   typedef enum logic [1:0] {
      ADCW_WU_OFF   = 2'b00,
      ADCW_WU_WAIT  = 2'b01,
      ADCW_WU_READY = 2'b10
   } adcw_wu_state_e;

   typedef logic [3:0]  adcw_code_t;
   typedef logic [7:0]  adcw_evt_t;
   typedef logic [15:0] adcw_ctrl_t;

endpackage

// File: adcw_warmup.sv
// Power-up delay counter of one dedicated converter core
`include "adcw_map.svh"

module adcw_warmup #(
   parameter int CNT_W = 16
) (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               power_on,
   input  wire logic               core_src_tick,
   input  wire adcw_pkg::adcw_code_t code,
   output logic                    ready
);

   if (CNT_W < `ADCW_CNT_MIN) begin : g_chk
      $error("adcw_warmup: CNT_W too small for the longest delay");
   end

   adcw_pkg::adcw_wu_state_e st_q, st_d;
   logic [CNT_W-1:0]         cnt_q, cnt_d;
   adcw_pkg::adcw_code_t     code_q, code_d;

   // Two to the power of the code, in core source clock periods
   function automatic logic [CNT_W-1:0] periods(input adcw_pkg::adcw_code_t c);
      logic [CNT_W-1:0] one;
      one = {{(CNT_W-1){1'b0}}, 1'b1};
      return one << c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Code is latched at power-up so a rewrite cannot stretch a running wait
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      code_d = code_q;
      case (st_q)
         adcw_pkg::ADCW_WU_OFF: begin
            if (power_on) begin
               st_d   = adcw_pkg::ADCW_WU_WAIT;
               cnt_d  = '0;
               code_d = code;
            end
         end
         adcw_pkg::ADCW_WU_WAIT: begin
            if (!power_on) begin
               st_d = adcw_pkg::ADCW_WU_OFF;
            end else if (core_src_tick) begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_d == periods(code_q)) begin
                  st_d = adcw_pkg::ADCW_WU_READY;
               end
            end
         end
         adcw_pkg::ADCW_WU_READY: begin
            if (!power_on) begin
               st_d = adcw_pkg::ADCW_WU_OFF;
            end
         end
         default: begin
            st_d = adcw_pkg::ADCW_WU_OFF;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q   <= adcw_pkg::ADCW_WU_OFF;
         cnt_q  <= '0;
         code_q <= '0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         code_q <= code_d;
      end
   end

   assign ready = (st_q == adcw_pkg::ADCW_WU_READY);

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   warmup_done_a: assert property (
      (st_q == adcw_pkg::ADCW_WU_WAIT) && power_on && core_src_tick &&
      (cnt_q == periods(code_q) - 1'b1) |=> ready)
      else $error("core not ready after its power-up delay");

   early_ready_a: assert property (
      $rose(ready) |-> $past(cnt_q) == periods($past(code_q)) - 1'b1)
      else $error("core ready before its power-up delay ended");

endmodule
